/* File: design/aot_map.svh */
`ifndef AOT_MAP_SVH
`define AOT_MAP_SVH
// ==========================================
// Offset code limits
`define AOT_CODE_W 4
`define AOT_CODE_ZERO 4'h0
`define AOT_CODE_FULL 4'hF
// ==========================================
// Conversion word layout
`define AOT_WORD_W 16
`define AOT_WORD_MSB 15
`define AOT_WORD_TOP3_LSB 13
`define AOT_TOP3_ZERO 3'h0
`define AOT_SLOT_W 8
`define AOT_NUM_SLOTS 256
// ==========================================
// Buffer and serial link timing
`define AOT_FIFO_DEPTH 32
`define AOT_CLK_HZ 50000000
`define AOT_LINK_BPS 2000000
`define AOT_BIT_CYCLES (`AOT_CLK_HZ / `AOT_LINK_BPS)
`endif

/* File: design/aot_pkg.sv */
`include "aot_map.svh"
package aot_pkg;
  // One conversion result with the pairing that produced it
  typedef struct packed {
    logic [`AOT_SLOT_W-1:0] slot;
    logic [`AOT_WORD_W-1:0] word;
  } aot_conv_s;
  // Serial sender states
  typedef enum logic [1:0] {
    AOT_IDLE = 2'b00,
    AOT_SHIFT = 2'b01
  } aot_tx_e;
endpackage

/* File: design/aot_fifo.sv */
`timescale 1ns/1ps
// ==========================================
// Synchronous FIFO with valid/ready on both sides
module aot_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  // Handshake decode
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];
  // Pointer wrap helper
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction
  // Pointers and fill level
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Data write
  always_ff @(posedge clock_in) begin
    if (push) mem[wr_ptr] <= in_data_in;
  end
endmodule // aot_fifo

/* File: design/aot_top.sv */
`timescale 1ns/1ps
`include "aot_map.svh"
// ==========================================
// Offset tracking and picture data sender
//
// Operation
// - Search starts with every offset code zero.
// - MSB set raises code, saturating at all ones.
// - Top three bits zero lowers code, else hold.
// - Each pairing adjusts only its own code.
// - Codes are kept and applied next conversion.
// - After picture, data sent serially at 2 Mb/s.
module aot_top #(
  parameter int NUM_SLOTS = `AOT_NUM_SLOTS,
  parameter int FIFO_DEPTH = `AOT_FIFO_DEPTH,
  parameter int BIT_CYCLES = `AOT_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Offset search control
  input wire logic search_start_in,
  input wire logic [`AOT_SLOT_W-1:0] slot_sel_in,
  output logic [`AOT_CODE_W-1:0] offset_code_out,
  // Conversion results
  input wire logic conv_valid_in,
  input wire aot_pkg::aot_conv_s conv_in,
  output logic conv_ready_out,
  // Picture end and serial link to processing_host
  input wire logic picture_done_in,
  output logic ser_data_out,
  output logic ser_frame_out,
  output logic busy_out
);

  // ==========================================
  // Offset memory

  // One code per channel and lock-in pairing
  logic [`AOT_CODE_W-1:0] code_mem [NUM_SLOTS];
  // Code of the pairing now converted
  wire [`AOT_CODE_W-1:0] cur_code;
  // Code of the pairing about to be converted
  wire [`AOT_CODE_W-1:0] sel_code;
  // Buffer fill side is free
  wire fifo_in_ready;
  // Conversion taken this cycle
  wire accept;
  // Adjusted code for the current pairing
  wire [`AOT_CODE_W-1:0] next_code;

  assign cur_code = code_mem[conv_in.slot];
  assign sel_code = code_mem[slot_sel_in];
  assign accept = conv_valid_in && fifo_in_ready;
  assign conv_ready_out = fifo_in_ready;

  // Step the code from the top bits of a word
  function automatic logic [`AOT_CODE_W-1:0] adjust(
    input logic [`AOT_CODE_W-1:0] code,
    input logic [`AOT_WORD_W-1:0] word
  );
    logic top_zero;
    top_zero = (word[`AOT_WORD_MSB:`AOT_WORD_TOP3_LSB] == `AOT_TOP3_ZERO);
    if (word[`AOT_WORD_MSB] && code != `AOT_CODE_FULL) begin
      adjust = code + 1'b1;
    end else if (top_zero && code != `AOT_CODE_ZERO) begin
      adjust = code - 1'b1;
    end else begin
      // Inside range or at a limit: hold
      adjust = code;
    end
  endfunction

  assign next_code = adjust(cur_code, conv_in.word);

  // Clear on start, else update only the converted pairing
  always_ff @(posedge clock_in) begin
    if (!rstn_in || search_start_in) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        code_mem[i] <= `AOT_CODE_ZERO;
      end
    end else if (accept) begin
      code_mem[conv_in.slot] <= next_code;
    end
  end

  // Present the stored code of the selected pairing
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      offset_code_out <= `AOT_CODE_ZERO;
    end else begin
      offset_code_out <= sel_code;
    end
  end

  // ==========================================
  // Picture buffer

  // Drain side of the buffer
  wire fifo_out_valid;
  wire [`AOT_WORD_W-1:0] fifo_out_data;
  wire fifo_out_ready;

  // Words wait here until the picture is complete
  aot_fifo #(
    .WIDTH(`AOT_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .in_valid_in(conv_valid_in),
    .in_data_in(conv_in.word),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_out_ready)
  );

  // ==========================================
  // Serial sender

  localparam int BCW = $clog2(BIT_CYCLES + 1);
  localparam int NBW = $clog2(`AOT_WORD_W + 1);

  // Sender state
  aot_pkg::aot_tx_e state;
  aot_pkg::aot_tx_e next_state;
  // A finished picture waits to be sent
  logic send_pending;
  // Word being shifted out, MSB first
  logic [`AOT_WORD_W-1:0] shreg;
  // Cycles within the current bit
  logic [BCW-1:0] cyc_cnt;
  // Bits already sent of the word
  logic [NBW-1:0] bit_cnt;

  // Decoded sender events
  wire idle = (state == aot_pkg::AOT_IDLE);
  wire bit_end = (cyc_cnt == BCW'(BIT_CYCLES - 1));
  wire word_end = bit_end && (bit_cnt == NBW'(`AOT_WORD_W - 1));
  wire pop = fifo_out_valid && fifo_out_ready;
  // Buffer empty ends the transfer
  wire drained = idle && !fifo_out_valid;

  // Only drain once a picture is complete
  assign fifo_out_ready = idle && send_pending;

  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      aot_pkg::AOT_IDLE: begin
        if (pop) next_state = aot_pkg::AOT_SHIFT;
      end
      aot_pkg::AOT_SHIFT: begin
        if (word_end) next_state = aot_pkg::AOT_IDLE;
      end
    endcase
  end

  // Picture pending flag; a new picture end wins over drain
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      send_pending <= 1'b0;
    end else if (picture_done_in) begin
      send_pending <= 1'b1;
    end else if (drained) begin
      send_pending <= 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= aot_pkg::AOT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit timing at the link rate
  always_ff @(posedge clock_in) begin
    if (!rstn_in || idle || bit_end) begin
      cyc_cnt <= '0;
    end else begin
      cyc_cnt <= cyc_cnt + 1'b1;
    end
  end

  // Bit count within a word
  always_ff @(posedge clock_in) begin
    if (!rstn_in || idle) begin
      bit_cnt <= '0;
    end else if (bit_end) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Shift register load and shift
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      shreg <= '0;
    end else if (pop) begin
      shreg <= fifo_out_data;
    end else if (!idle && bit_end) begin
      shreg <= {shreg[`AOT_WORD_W-2:0], 1'b0};
    end
  end

  // Registered link outputs
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ser_data_out <= 1'b0;
      ser_frame_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      ser_data_out <= (next_state == aot_pkg::AOT_SHIFT) ?
                      (pop ? fifo_out_data[`AOT_WORD_MSB] :
                       (bit_end ? shreg[`AOT_WORD_MSB-1] : shreg[`AOT_WORD_MSB])) :
                      1'b0;
      ser_frame_out <= (next_state == aot_pkg::AOT_SHIFT);
      busy_out <= send_pending || (next_state == aot_pkg::AOT_SHIFT);
    end
  end

  // ==========================================
  // Assertions

  // Start of a word on the link
  sequence s_pop;
    pop;
  endsequence

  // Frame held on the link for the first eight cycles of its first bit
  sequence s_first_bit;
    ser_frame_out [*8];
  endsequence

  property p_clear_on_start;
    @(posedge clock_in) disable iff (!rstn_in)
    search_start_in |=> (cur_code == `AOT_CODE_ZERO) && (sel_code == `AOT_CODE_ZERO);
  endproperty
  a_clear_on_start: assert property (p_clear_on_start)
    else $error("offset codes not cleared at search start");

  property p_raise;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && !search_start_in && conv_in.word[`AOT_WORD_MSB] &&
     cur_code != `AOT_CODE_FULL)
    |=> code_mem[$past(conv_in.slot)] == $past(cur_code) + 4'h1;
  endproperty
  a_raise: assert property (p_raise)
    else $error("offset code not raised on high word");

  property p_saturate;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && !search_start_in && conv_in.word[`AOT_WORD_MSB] &&
     cur_code == `AOT_CODE_FULL)
    |=> code_mem[$past(conv_in.slot)] == `AOT_CODE_FULL;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("offset code went past all ones");

  property p_lower;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && !search_start_in && conv_in.word[15:13] == 3'h0 &&
     cur_code != `AOT_CODE_ZERO)
    |=> code_mem[$past(conv_in.slot)] == $past(cur_code) - 4'h1;
  endproperty
  a_lower: assert property (p_lower)
    else $error("offset code not lowered on low word");

  property p_hold_mid;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && !search_start_in && !conv_in.word[15] && conv_in.word[15:13] != 3'h0)
    |=> code_mem[$past(conv_in.slot)] == $past(cur_code);
  endproperty
  a_hold_mid: assert property (p_hold_mid)
    else $error("offset code changed for in-range word");

  property p_floor;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && conv_in.word[15:13] == 3'h0 && cur_code == `AOT_CODE_ZERO)
    |=> code_mem[$past(conv_in.slot)] == `AOT_CODE_ZERO;
  endproperty
  a_floor: assert property (p_floor)
    else $error("offset code wrapped below zero");

  property p_isolate;
    @(posedge clock_in) disable iff (!rstn_in)
    (accept && !search_start_in && slot_sel_in != conv_in.slot)
    ##1 $stable(slot_sel_in) |-> sel_code == $past(sel_code);
  endproperty
  a_isolate: assert property (p_isolate)
    else $error("adjustment disturbed another pairing");

  property p_apply;
    @(posedge clock_in) disable iff (!rstn_in)
    ##1 offset_code_out == $past(sel_code);
  endproperty
  a_apply: assert property (p_apply)
    else $error("stored offset code not applied");

  property p_word_start;
    @(posedge clock_in) disable iff (!rstn_in)
    s_pop |=> s_first_bit ##0 (ser_data_out == $past(fifo_out_data[15], 8));
  endproperty
  a_word_start: assert property (p_word_start)
    else $error("link word did not start after pop");

  property p_only_after_picture;
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(ser_frame_out) |-> $past(send_pending);
  endproperty
  a_only_after_picture: assert property (p_only_after_picture)
    else $error("data sent before picture complete");

  property p_bit_rate;
    @(posedge clock_in) disable iff (!rstn_in)
    (!idle && cyc_cnt == '0 && $past(bit_end)) |-> ##24 bit_end;
  endproperty
  a_bit_rate: assert property (p_bit_rate)
    else $error("link bit period is not 25 cycles");

endmodule // aot_top

/* File: verification/aot_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// Serial receiver standing in for processing_host
module aot_host_model #(
  parameter int BIT_CYCLES = 25
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Serial link
  input wire logic ser_data_in,
  input wire logic ser_frame_in,
  // Received word
  output logic [15:0] word_out,
  output logic word_valid_out,
  output logic [15:0] frame_len_out
);
  logic [15:0] cnt; // Cycles into the frame
  logic [15:0] shift; // Bits gathered so far
  // Sample mid-bit so edge jitter never matters, emit at frame end
  always @(posedge clock_in) begin
    word_valid_out <= 1'b0;
    if (!rstn_in) begin
      cnt <= 16'h0000;
    end else if (ser_frame_in) begin
      cnt <= cnt + 16'h0001;
      if (cnt % BIT_CYCLES == BIT_CYCLES / 2) begin
        shift <= {shift[14:0], ser_data_in};
      end
    end else if (cnt != 16'h0000) begin
      word_out <= shift;
      frame_len_out <= cnt;
      word_valid_out <= 1'b1;
      cnt <= 16'h0000;
    end
  end
endmodule // aot_host_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`include "aot_map.svh"
// ==========================================
// Self-checking bench for offset tracking and sender
module testbench;
  localparam int BITS = 25; // Cycles per link bit
  logic clock_in = 1'b0; // 50 MHz clock
  logic rstn_in = 1'b0; // Reset, active low
  logic search_start_in = 1'b0;
  logic [7:0] slot_sel_in = 8'h00;
  logic conv_valid_in = 1'b0;
  aot_pkg::aot_conv_s conv_in = '0;
  logic picture_done_in = 1'b0;
  logic [3:0] offset_code_out;
  logic conv_ready_out, ser_data_out, ser_frame_out, busy_out;
  logic [15:0] rx_word, rx_len;
  logic rx_valid;
  logic [15:0] exp_q[$]; // Words accepted, in order
  logic [15:0] rx_q[$]; // Words received
  int miscompares = 0;
  int total_checks = 0;
  // ==========================================
  // Design and far side
  aot_top #(.BIT_CYCLES(BITS)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
    .search_start_in(search_start_in), .slot_sel_in(slot_sel_in),
    .offset_code_out(offset_code_out), .conv_valid_in(conv_valid_in),
    .conv_in(conv_in), .conv_ready_out(conv_ready_out),
    .picture_done_in(picture_done_in), .ser_data_out(ser_data_out),
    .ser_frame_out(ser_frame_out), .busy_out(busy_out));
  aot_host_model #(.BIT_CYCLES(BITS)) i_host (.clock_in(clock_in), .rstn_in(rstn_in),
    .ser_data_in(ser_data_out), .ser_frame_in(ser_frame_out), .word_out(rx_word),
    .word_valid_out(rx_valid), .frame_len_out(rx_len));
  // Clock generator
  always #10 clock_in = ~clock_in;
  // Collect received words
  always @(posedge clock_in) begin
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_word);
    end
  end
  // ==========================================
  // Shared helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] a);
    total_checks++;
    if (a !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic give_up();
    miscompares++;
    report_and_stop();
  endtask
  // Offer one conversion and hold it until taken
  task automatic send(input logic [7:0] s, input logic [15:0] w);
    int n;
    conv_valid_in <= 1'b1;
    conv_in <= '{slot: s, word: w};
    n = 0;
    @(negedge clock_in);
    while (conv_ready_out !== 1'b1) begin
      n++;
      if (n > 30000) give_up();
      @(negedge clock_in);
    end
    @(posedge clock_in);
    exp_q.push_back(w);
    conv_valid_in <= 1'b0;
    @(posedge clock_in);
  endtask
  // Select a pairing and compare its code
  task automatic code_is(input logic [7:0] s, input logic [3:0] e);
    slot_sel_in <= s;
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
    chk({12'h000, e}, {12'h000, offset_code_out});
    @(posedge clock_in);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    code_is(8'h05, 4'h0);
    @(negedge clock_in);
    chk(16'h0001, {15'h0000, conv_ready_out});
    chk(16'h0000, {14'h0000, busy_out, ser_frame_out});
    @(posedge clock_in);
  endtask
  // Reset in mid-run clears codes and drops buffered words
  task automatic t_reset_mid();
    send(8'h09, 16'h8000);
    code_is(8'h09, 4'h1);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    exp_q.delete();
    @(posedge clock_in);
    code_is(8'h09, 4'h0);
    t_reset();
  endtask
  task automatic t_up_down();
    for (int i = 0; i < 17; i++) send(8'h05, 16'h8000);
    code_is(8'h05, 4'hF);
    code_is(8'h06, 4'h0);
    send(8'h05, 16'h4000);
    send(8'h05, 16'h2000);
    code_is(8'h05, 4'hF);
    send(8'h05, 16'h1FFF);
    code_is(8'h05, 4'hE);
    code_is(8'h05, 4'hE);
  endtask
  task automatic t_link();
    int n;
    @(negedge clock_in);
    chk(16'h0000, {14'h0000, ser_frame_out, ser_data_out});
    @(posedge clock_in);
    picture_done_in <= 1'b1;
    @(posedge clock_in);
    picture_done_in <= 1'b0;
    @(posedge clock_in);
    @(negedge clock_in);
    chk(16'h0001, {15'h0000, busy_out});
    n = 0;
    while (rx_q.size() < exp_q.size()) begin
      n++;
      if (n > 20000) give_up();
      @(posedge clock_in);
    end
    chk(16'(16 * BITS), rx_len);
    while (exp_q.size() > 0) chk(exp_q.pop_front(), rx_q.pop_front());
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
    chk(16'h0000, {15'h0000, busy_out});
    @(posedge clock_in);
  endtask
  task automatic t_search();
    send(8'h03, 16'h8000);
    search_start_in <= 1'b1;
    @(posedge clock_in);
    search_start_in <= 1'b0;
    code_is(8'h05, 4'h0);
    code_is(8'h03, 4'h0);
    send(8'h05, 16'h0000);
    code_is(8'h05, 4'h0);
  endtask
  task automatic t_fill();
    int k;
    k = 0;
    @(negedge clock_in);
    while (conv_ready_out === 1'b1 && k < 40) begin
      @(posedge clock_in);
      send(8'h07, 16'hA55A ^ 16'(k));
      k++;
      @(negedge clock_in);
    end
    chk(16'(`AOT_FIFO_DEPTH), 16'(exp_q.size()));
    code_is(8'h07, 4'hF);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_up_down();
    t_link();
    t_search();
    t_fill();
    t_link();
    t_reset_mid();
    report_and_stop();
  end
endmodule // testbench
